// File: include/move_or_rotate_consts.svh
// constants for the move, or and rotate datapath
`ifndef MOVE_OR_ROTATE_CONSTS_SVH
`define MOVE_OR_ROTATE_CONSTS_SVH
`define DATA_WIDTH     8
`define ACC_RESET      8'h00
`define CARRY_RESET    1'b0
`define ZERO_RESET     1'b0
`define WDATA_RESET    8'h00
`define WE_RESET       1'b0
`define MSB_POS        7
`endif

// File: include/move_or_rotate_pkg.sv
// types for the move, or and rotate datapath
package move_or_rotate_pkg;
  typedef enum logic [3:0] {
    op_none,
    long_move_to_accumulator_op,
    long_move_op,
    or_to_accumulator_op,
    or_to_memory_op,
    rotate_left_memory_op,
    rotate_left_to_accumulator_op,
    rotate_left_carry_memory_op,
    rotate_left_carry_to_accumulator_op,
    rotate_right_memory_op,
    rotate_right_to_accumulator_op,
    rotate_right_carry_memory_op,
    rotate_right_carry_to_accumulator_op
  } op_type;
endpackage : move_or_rotate_pkg

// File: rtl/rotate_unit.sv
// one-bit rotate of a byte, plain or through carry
`timescale 1ns/1ps
`include "move_or_rotate_consts.svh"
module rotate_unit #(
  parameter int WIDTH = `DATA_WIDTH
) (
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic             carry_in,
  input  wire logic             right,
  input  wire logic             through_carry,
  output logic      [WIDTH-1:0] result,
  output logic                  carry_out
);
  wire logic fill_left;
  wire logic fill_right;
  assign fill_left  = through_carry ? carry_in : operand[WIDTH-1];
  assign fill_right = through_carry ? carry_in : operand[0];
  assign result     = right ? {fill_right, operand[WIDTH-1:1]}
                            : {operand[WIDTH-2:0], fill_left};
  assign carry_out  = right ? operand[0] : operand[WIDTH-1];
endmodule : rotate_unit

// File: rtl/move_or_rotate_datapath.sv
// datapath for moves, or and one-bit rotates on data memory
// Behaviour
// - move memory to accumulator, flags unchanged
// - move accumulator to memory, flags unchanged
// - or into accumulator, zero flag only
// - or into memory, zero flag only
// - rotate memory left, write back, no flags
// - rotate left into accumulator, no flags
// - rotate left through carry into memory
// - rotate left through carry into accumulator
// - rotate memory right, write back, no flags
// - rotate right into accumulator, no flags
// - rotate right through carry into memory
// - rotate right through carry into accumulator
`timescale 1ns/1ps
`include "move_or_rotate_consts.svh"
module move_or_rotate_datapath #(
  parameter int WIDTH = `DATA_WIDTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire move_or_rotate_pkg::op_type op,
  input  wire logic                       op_valid,
  input  wire logic [WIDTH-1:0]           mem_rdata,
  output logic      [WIDTH-1:0]           accumulator,
  output logic                            carry_flag,
  output logic                            zero_flag,
  output logic      [WIDTH-1:0]           mem_wdata,
  output logic                            mem_we
);
  import move_or_rotate_pkg::*;

  // working registers and their next values
  logic [WIDTH-1:0] acc_q;
  logic [WIDTH-1:0] acc_d;
  logic             carry_q;
  logic             carry_d;
  logic             zero_q;
  logic             zero_d;
  logic [WIDTH-1:0] wdata_q;
  logic [WIDTH-1:0] wdata_d;
  logic             we_q;
  logic             we_d;

  // codes that combine accumulator and memory by or
  function automatic logic is_or_op(input op_type code);
    case (code)
      or_to_accumulator_op,
      or_to_memory_op: is_or_op = 1'b1;
      default:         is_or_op = 1'b0;
    endcase
  endfunction : is_or_op

  // all eight one-bit rotates, plain or through carry
  function automatic logic is_rotate_op(input op_type code);
    case (code)
      rotate_left_memory_op,
      rotate_left_to_accumulator_op,
      rotate_left_carry_memory_op,
      rotate_left_carry_to_accumulator_op,
      rotate_right_memory_op,
      rotate_right_to_accumulator_op,
      rotate_right_carry_memory_op,
      rotate_right_carry_to_accumulator_op: is_rotate_op = 1'b1;
      default:                              is_rotate_op = 1'b0;
    endcase
  endfunction : is_rotate_op

  // rotates that move bits towards bit zero
  function automatic logic is_right_rotate(input op_type code);
    case (code)
      rotate_right_memory_op,
      rotate_right_to_accumulator_op,
      rotate_right_carry_memory_op,
      rotate_right_carry_to_accumulator_op: is_right_rotate = 1'b1;
      default:                              is_right_rotate = 1'b0;
    endcase
  endfunction : is_right_rotate

  // rotates that run through the carry flag and update it
  function automatic logic is_carry_rotate(input op_type code);
    case (code)
      rotate_left_carry_memory_op,
      rotate_left_carry_to_accumulator_op,
      rotate_right_carry_memory_op,
      rotate_right_carry_to_accumulator_op: is_carry_rotate = 1'b1;
      default:                              is_carry_rotate = 1'b0;
    endcase
  endfunction : is_carry_rotate

  // the one move that copies the accumulator out
  function automatic logic is_store_op(input op_type code);
    case (code)
      long_move_op: is_store_op = 1'b1;
      default:      is_store_op = 1'b0;
    endcase
  endfunction : is_store_op

  // codes whose result lands in data memory
  function automatic logic writes_memory(input op_type code);
    case (code)
      long_move_op,
      or_to_memory_op,
      rotate_left_memory_op,
      rotate_left_carry_memory_op,
      rotate_right_memory_op,
      rotate_right_carry_memory_op: writes_memory = 1'b1;
      default:                      writes_memory = 1'b0;
    endcase
  endfunction : writes_memory

  // codes whose result lands in the accumulator
  function automatic logic loads_accumulator(input op_type code);
    case (code)
      long_move_to_accumulator_op,
      or_to_accumulator_op,
      rotate_left_to_accumulator_op,
      rotate_left_carry_to_accumulator_op,
      rotate_right_to_accumulator_op,
      rotate_right_carry_to_accumulator_op: loads_accumulator = 1'b1;
      default:                              loads_accumulator = 1'b0;
    endcase
  endfunction : loads_accumulator

  // operand paths and landing enables
  wire logic [WIDTH-1:0] or_result;
  wire logic [WIDTH-1:0] rot_result;
  wire logic             rot_carry;
  wire logic             is_right;
  wire logic             is_carry_rot;
  wire logic             or_zero;
  wire logic [WIDTH-1:0] op_result;
  wire logic             acc_load;
  wire logic             mem_write;
  wire logic             zero_update;
  wire logic             carry_update;

  assign or_result    = acc_q | mem_rdata;
  assign or_zero      = (or_result == '0);
  assign is_right     = is_right_rotate(op);
  assign is_carry_rot = is_carry_rotate(op);

  // one rotator serves all eight rotate codes
  rotate_unit #(.WIDTH(WIDTH)) u_rot (
    .operand       (mem_rdata),
    .carry_in      (carry_q),
    .right         (is_right),
    .through_carry (is_carry_rot),
    .result        (rot_result),
    .carry_out     (rot_carry)
  );

  // unknown codes fall through to memory data, but no enable fires
  // for them, so nothing lands
  assign op_result    = is_or_op(op)        ? or_result  :
                        is_rotate_op(op)    ? rot_result :
                        is_store_op(op)     ? acc_q      :
                                              mem_rdata;

  // an idle cycle or a code outside these groups holds all state but the write strobe, which drops
  assign acc_load     = op_valid && loads_accumulator(op);
  assign mem_write    = op_valid && writes_memory(op);
  assign zero_update  = op_valid && is_or_op(op);
  assign carry_update = op_valid && is_carry_rot;

  // next values hold unless their enable is set; the write strobe just follows mem_write
  assign acc_d   = acc_load     ? op_result : acc_q;
  assign wdata_d = mem_write    ? op_result : wdata_q;
  assign we_d    = mem_write;
  assign zero_d  = zero_update  ? or_zero   : zero_q;
  assign carry_d = carry_update ? rot_carry : carry_q;

  // accumulator, loaded by moves, or and rotates into it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= `ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // memory write-back byte, kept between writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdata_q <= `WDATA_RESET;
    end else begin
      wdata_q <= wdata_d;
    end
  end

  // one-cycle write strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      we_q <= `WE_RESET;
    end else begin
      we_q <= we_d;
    end
  end

  // zero flag, touched only by the or codes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      zero_q <= `ZERO_RESET;
    end else begin
      zero_q <= zero_d;
    end
  end

  // carry flag, touched only by the carry rotates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      carry_q <= `CARRY_RESET;
    end else begin
      carry_q <= carry_d;
    end
  end

  // outputs straight from the flops
  assign accumulator = acc_q;
  assign carry_flag  = carry_q;
  assign zero_flag   = zero_q;
  assign mem_wdata   = wdata_q;
  assign mem_we      = we_q;
endmodule : move_or_rotate_datapath

// File: tb/data_mem_model.sv
// data-memory byte facing the datapath
`timescale 1ns/1ps
module data_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       set_en,
  input  wire logic       mem_we,
  input  wire logic [7:0] set_val,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata
);
  // bench preload wins over a write
  always_ff @(posedge clk_sys) begin
    if (set_en) mem_rdata <= set_val;
    else if (mem_we) mem_rdata <= mem_wdata;
  end
endmodule : data_mem_model

// File: tb/move_or_rotate_datapath_chk.sv
// port assertions for the datapath
`timescale 1ns/1ps
module move_or_rotate_datapath_chk (
  input wire logic                       clk_sys,
  input wire logic                       rstn,
  input wire logic                       op_valid,
  input wire logic                       carry_flag,
  input wire logic                       zero_flag,
  input wire logic                       mem_we,
  input wire move_or_rotate_pkg::op_type op,
  input wire logic [7:0]                 mem_rdata,
  input wire logic [7:0]                 accumulator,
  input wire logic [7:0]                 mem_wdata
);
  import move_or_rotate_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire op_type act = op_valid ? op : op_none;
  wire [7:0]   rd  = mem_rdata;
  wire [7:0]   acc = accumulator;
  a_move_load: assert property (act == long_move_to_accumulator_op |=>
    acc == $past(rd) && $stable(zero_flag)) else $error("load");
  a_move_store: assert property (act == long_move_op |=>
    mem_we && mem_wdata == $past(acc)) else $error("store");
  a_or_zero: assert property (act == or_to_accumulator_op |=>
    acc == ($past(acc) | $past(rd)) && zero_flag == !acc) else $error("or");
  a_or_mem: assert property (act == or_to_memory_op |=>
    mem_wdata == ($past(acc) | $past(rd)) && $stable(carry_flag)) else $error("or mem");
  a_rot_left: assert property (act == rotate_left_memory_op |=>
    mem_we && mem_wdata == {$past(rd[6:0]), $past(rd[7])}) else $error("left");
  a_ring_left: assert property (act == rotate_left_carry_to_accumulator_op |=>
    {carry_flag, acc} == {$past(rd), $past(carry_flag)}) else $error("ring left");
  a_rot_right: assert property (act == rotate_right_to_accumulator_op |=>
    acc == {$past(rd[0]), $past(rd[7:1])} && !mem_we) else $error("right");
  a_ring_right: assert property (act == rotate_right_carry_memory_op |=>
    {mem_wdata, carry_flag} == {$past(carry_flag), $past(rd)}) else $error("ring right");
  a_ring_left_mem: assert property (act == rotate_left_carry_memory_op |=>
    mem_we && {carry_flag, mem_wdata} == {$past(rd), $past(carry_flag)})
    else $error("ring left mem");
  a_ring_right_acc: assert property (act == rotate_right_carry_to_accumulator_op |=>
    !mem_we && {acc, carry_flag} == {$past(carry_flag), $past(rd)})
    else $error("ring right acc");
  c_zero: cover property (act == or_to_memory_op ##1 zero_flag);
  c_ring: cover property (act == rotate_right_carry_to_accumulator_op);
  c_write: cover property (mem_we ##1 !mem_we);
endmodule : move_or_rotate_datapath_chk
bind move_or_rotate_datapath move_or_rotate_datapath_chk i_move_or_rotate_datapath_chk (
  .clk_sys     (clk_sys),
  .rstn        (rstn),
  .op_valid    (op_valid),
  .carry_flag  (carry_flag),
  .zero_flag   (zero_flag),
  .mem_we      (mem_we),
  .op          (op),
  .mem_rdata   (mem_rdata),
  .accumulator (accumulator),
  .mem_wdata   (mem_wdata)
);

// File: tb/move_or_rotate_datapath_tb.sv
// bench for the move, or and rotate datapath
`timescale 1ns/1ps
module move_or_rotate_datapath_tb;
  import move_or_rotate_pkg::*;
  logic clk_sys = 1'h0, rstn = 1'h0, op_valid = 1'h0, set_en = 1'h0;
  logic mem_we, carry_flag, zero_flag;
  logic [7:0] set_val = 8'h00, mem_rdata, accumulator, mem_wdata;
  op_type op = op_none;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  move_or_rotate_datapath i_move_or_rotate_datapath (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .op          (op),
    .op_valid    (op_valid),
    .mem_rdata   (mem_rdata),
    .accumulator (accumulator),
    .carry_flag  (carry_flag),
    .zero_flag   (zero_flag),
    .mem_wdata   (mem_wdata),
    .mem_we      (mem_we)
  );
  data_mem_model i_data_mem_model (
    .clk_sys   (clk_sys),
    .set_en    (set_en),
    .mem_we    (mem_we),
    .set_val   (set_val),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 200) begin
      n_errors++;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [23:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // expected: acc, memory, carry nibble, zero nibble
  task run(input op_type o, input logic [7:0] m, input logic [23:0] e);
    @(negedge clk_sys) set_en = 1'h1;
    set_val = m;
    @(negedge clk_sys) set_en = 1'h0;
    op = o;
    op_valid = 1'h1;
    @(negedge clk_sys) op_valid = 1'h0;
    @(negedge clk_sys) chk("state", {accumulator, mem_rdata, 3'h0, carry_flag, 3'h0, zero_flag}, e);
  endtask : run
  task t_move_or;
    run(or_to_memory_op, 8'h00, 24'h000001);
    run(long_move_to_accumulator_op, 8'hA5, 24'hA5A501);
    run(or_to_accumulator_op, 8'h5A, 24'hFF5A00);
    run(long_move_op, 8'h3C, 24'hFFFF00);
    $display("move and or done");
  endtask : t_move_or
  task t_rot;
    run(rotate_left_carry_memory_op, 8'h81, 24'hFF0210);
    run(rotate_left_carry_to_accumulator_op, 8'h01, 24'h030100);
    run(rotate_right_carry_memory_op, 8'h01, 24'h030010);
    run(rotate_left_memory_op, 8'h81, 24'h030310);
    run(rotate_left_to_accumulator_op, 8'hC1, 24'h83C110);
    run(rotate_right_memory_op, 8'h81, 24'h83C010);
    run(rotate_right_to_accumulator_op, 8'h81, 24'hC08110);
    run(rotate_right_carry_to_accumulator_op, 8'h02, 24'h810200);
    $display("rotate done");
  endtask : t_rot
  // two carry rotates back to back, the second sees the first's carry
  task t_chain;
    @(negedge clk_sys) set_en = 1'h1;
    set_val = 8'h80;
    @(negedge clk_sys) set_en = 1'h0;
    op = rotate_left_carry_to_accumulator_op;
    op_valid = 1'h1;
    repeat (2) @(negedge clk_sys);
    op_valid = 1'h0;
    @(negedge clk_sys) chk("chain", {accumulator, mem_rdata, 3'h0, carry_flag, 3'h0, zero_flag}, 24'h018010);
    $display("back to back done");
  endtask : t_chain
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'h1;
    t_move_or;
    t_rot;
    t_chain;
    close_out;
  end
endmodule : move_or_rotate_datapath_tb
